// [common/aitt_pkg.sv]
// constants shared by the adc injection trigger timer
package aitt_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] CTRL_IDX  = 16'hc000;
    localparam logic [15:0] START_IDX = 16'hc002;
    localparam logic [15:0] END_IDX   = 16'hc004;
    localparam logic [15:0] CUR_IDX   = 16'hc006;
    localparam logic [31:0] CTRL_ADDR  = {14'h0000, CTRL_IDX, 2'h0};
    localparam logic [31:0] START_ADDR = {14'h0000, START_IDX, 2'h0};
    localparam logic [31:0] END_ADDR   = {14'h0000, END_IDX, 2'h0};
    localparam logic [31:0] CUR_ADDR   = {14'h0000, CUR_IDX, 2'h0};
    // reset values
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [15:0] START_RST = 16'h0000;
    localparam logic [15:0] END_RST   = 16'h0000;
    localparam logic [15:0] CUR_RST   = 16'h0000;
    // control field positions
    localparam int TEN_POS  = 0;  // timer enable
    localparam int DIR_POS  = 1;  // direction, 1 = up
    localparam int LOAD_POS = 2;  // load enable
    localparam int CONT_POS = 3;  // continue mode
    localparam int OE_POS   = 4;  // trigger output enable
    localparam int CKM_POS  = 5;  // clock mode, must stay 0
    localparam int FRQ_LSB  = 6;  // frequency field low bit
    localparam int FRQ_MSB  = 9;  // frequency field high bit
    // writable control bits; bits 15:10 read as zero
    localparam logic [15:0] CTRL_WMASK = 16'h03ff;
    // prescaler counter width: largest division is 2**17
    localparam int PRESC_W = 17;
    localparam logic [PRESC_W-1:0] PRESC_ALL = 17'h1ffff;
    localparam logic [3:0] FRQ_MAX = 4'hf;
    // trigger pulse length in internal clock cycles
    localparam int TRIG_CYCLES = 2;
    localparam logic [1:0] TRIG_LAST = 2'(TRIG_CYCLES - 1);
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [common/aitt_presc_if.sv]
// link between the timer core and its prescaler
`timescale 1ns/10ps
interface aitt_presc_if;
    logic       run;   // prescaler counts while high
    logic [3:0] frq;   // frequency field
    logic       tick;  // one-cycle counting clock enable
    modport core  (output run, output frq, input tick);
    modport presc (input run, input frq, output tick);
endinterface

// [design/aitt_prescaler.sv]
// exponential prescaler making the counting clock enable
`timescale 1ns/10ps
module aitt_prescaler (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    aitt_presc_if.presc       pif
);
    logic [aitt_pkg::PRESC_W-1:0] div_reg;   // free-running divider
    logic [aitt_pkg::PRESC_W-1:0] mask;      // low 2+frq bits set

    // division is 2**(2+frq): tick when the low bits are all ones
    always_comb begin
        mask = aitt_pkg::PRESC_ALL >> (aitt_pkg::FRQ_MAX - pif.frq);
        pif.tick = pif.run && ((div_reg & mask) == mask);
    end

    // divider cleared while stopped, so the first period is whole
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_reg <= '0;
        end else if (!pif.run) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
endmodule

// [design/aitt_timer.sv]
// adc injection trigger timer with axi4-lite register slave
//
// Notes on behaviour
// - at end, load and continue reload start
// - enable rise loads start on next tick
// - one counting tick per value, both ends
// - current compared with end value continuously
// - next current: start, increment or decrement
// - on equality trigger, reload, stop or continue
// - clock mode zero: prescaled system clock counts
// - trigger is two-cycle pulse on equality rise
// - four registers at fixed indices, reset zero
// - current read-only; start, end full read-write
// - enable zero holds current value
// - direction zero counts down, one counts up
// - no load: continue counts on, stop freezes
// - trigger only with output enable set
`timescale 1ns/10ps
module aitt_timer (
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // write address channel
    input  wire logic [31:0] S_AXI_AWADDR_I,
    input  wire logic [2:0]  S_AXI_AWPROT_I,
    input  wire logic        S_AXI_AWVALID_I,
    output logic             S_AXI_AWREADY_O,
    // write data channel
    input  wire logic [31:0] S_AXI_WDATA_I,
    input  wire logic [3:0]  S_AXI_WSTRB_I,
    input  wire logic        S_AXI_WVALID_I,
    output logic             S_AXI_WREADY_O,
    // write response channel
    output logic [1:0]       S_AXI_BRESP_O,
    output logic             S_AXI_BVALID_O,
    input  wire logic        S_AXI_BREADY_I,
    // read address channel
    input  wire logic [31:0] S_AXI_ARADDR_I,
    input  wire logic [2:0]  S_AXI_ARPROT_I,
    input  wire logic        S_AXI_ARVALID_I,
    output logic             S_AXI_ARREADY_O,
    // read data channel
    output logic [31:0]      S_AXI_RDATA_O,
    output logic [1:0]       S_AXI_RRESP_O,
    output logic             S_AXI_RVALID_O,
    input  wire logic        S_AXI_RREADY_I,
    // trigger toward the adc channel injection logic
    output logic             ADC_INJECT_TRIGGER_O
);

    // ---------------- register file ----------------
    logic [15:0] ctrl_reg;        // control and prescaler field
    logic [15:0] start_reg;       // start value
    logic [15:0] end_reg;         // end value
    logic [15:0] cur_reg;         // current value, counts

    // ---------------- axi write side ----------------
    logic        aw_held_reg;     // write address captured
    logic [31:0] aw_addr_reg;     // captured write address
    logic        w_held_reg;      // write data captured
    logic [31:0] w_data_reg;      // captured write data
    logic [3:0]  w_strb_reg;      // captured byte strobes
    logic        bvalid_reg;      // write response pending
    logic [1:0]  bresp_reg;       // write response code
    logic        do_write;        // both halves held, commit now

    // ---------------- axi read side ----------------
    logic        rvalid_reg;      // read data pending
    logic [31:0] rdata_reg;       // read data
    logic [1:0]  rresp_reg;       // read response code

    // ---------------- counting state ----------------
    logic        ten_d_reg;       // enable of the previous cycle
    logic        load_pend_reg;   // start load awaits first tick
    logic        eq_d_reg;        // qualified equality, delayed
    logic [1:0]  trig_cnt_reg;    // trigger cycles still to run
    logic        trig_reg;        // registered trigger output

    // ---------------- decoded control ----------------
    logic        timer_enable_bit;             // timer enable
    logic        dir_up;          // direction, 1 = up
    logic        load_en;         // load enable
    logic        cont;            // continue mode
    logic        out_en;          // trigger output enable
    logic        ckm;             // clock mode
    logic        ten_rise;        // enable just went high
    logic        at_end;          // current equals end value
    logic        eq_q;            // equality while really counting
    logic        eq_rise;         // differentiated equality

    aitt_presc_if pif ();         // prescaler link

    // merge a 16-bit register with strobed write data
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [15:0] res;
        res = old;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction

    // true when an address hits one of the four registers
    function automatic logic hit(input logic [31:0] a);
        return (a == aitt_pkg::CTRL_ADDR) || (a == aitt_pkg::START_ADDR)
            || (a == aitt_pkg::END_ADDR) || (a == aitt_pkg::CUR_ADDR);
    endfunction

    // control field decode
    always_comb begin
        timer_enable_bit    = ctrl_reg[aitt_pkg::TEN_POS];
        dir_up = ctrl_reg[aitt_pkg::DIR_POS];
        load_en = ctrl_reg[aitt_pkg::LOAD_POS];
        cont   = ctrl_reg[aitt_pkg::CONT_POS];
        out_en = ctrl_reg[aitt_pkg::OE_POS];
        ckm    = ctrl_reg[aitt_pkg::CKM_POS];
    end

    // prescaler runs only enabled and in internal clock mode;
    // clock mode one has no source here, so the count then stands
    assign pif.run = timer_enable_bit && !ckm;
    assign pif.frq = ctrl_reg[aitt_pkg::FRQ_MSB:aitt_pkg::FRQ_LSB];

    aitt_prescaler u_presc (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .pif     (pif)
    );

    // ---------------- axi handshakes ----------------
    // one write in flight: no new halves while a response waits
    assign S_AXI_AWREADY_O = !aw_held_reg && !bvalid_reg;
    assign S_AXI_WREADY_O  = !w_held_reg && !bvalid_reg;
    assign S_AXI_ARREADY_O = !rvalid_reg;
    assign S_AXI_BVALID_O  = bvalid_reg;
    assign S_AXI_BRESP_O   = bresp_reg;
    assign S_AXI_RVALID_O  = rvalid_reg;
    assign S_AXI_RDATA_O   = rdata_reg;
    assign S_AXI_RRESP_O   = rresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // write address capture; either half may come first
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 32'h0000_0000;
        end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR_I;
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // write data capture
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_held_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response: unmapped address answers with slverr
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= aitt_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= hit(aw_addr_reg) ? aitt_pkg::RESP_OKAY
                                           : aitt_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    // read channel: data one cycle after the address is taken
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= aitt_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= aitt_pkg::RESP_OKAY;
            case (S_AXI_ARADDR_I)
                aitt_pkg::CTRL_ADDR: begin
                    rdata_reg <= {16'h0000, ctrl_reg};
                end
                aitt_pkg::START_ADDR: begin
                    rdata_reg <= {16'h0000, start_reg};
                end
                aitt_pkg::END_ADDR: begin
                    rdata_reg <= {16'h0000, end_reg};
                end
                aitt_pkg::CUR_ADDR: begin
                    rdata_reg <= {16'h0000, cur_reg};
                end
                default: begin
                    // unmapped: zero data and an error answer
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= aitt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (S_AXI_RREADY_I) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ---------------- software registers ----------------
    // control, start and end values; all reset to zero
    // changes other than enable while running are not guarded:
    // software is expected to reconfigure only when stopped
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            ctrl_reg  <= aitt_pkg::CTRL_RST;
            start_reg <= aitt_pkg::START_RST;
            end_reg   <= aitt_pkg::END_RST;
        end else if (do_write) begin
            case (aw_addr_reg)
                aitt_pkg::CTRL_ADDR: begin
                    ctrl_reg <= merge16(ctrl_reg, w_data_reg, w_strb_reg)
                                & aitt_pkg::CTRL_WMASK;
                end
                aitt_pkg::START_ADDR: begin
                    start_reg <= merge16(start_reg, w_data_reg,
                                         w_strb_reg);
                end
                aitt_pkg::END_ADDR: begin
                    end_reg <= merge16(end_reg, w_data_reg,
                                       w_strb_reg);
                end
                default: begin
                    // current value and unmapped: writes are ignored
                end
            endcase
        end
    end

    // ---------------- counting ----------------
    assign ten_rise = timer_enable_bit && !ten_d_reg;
    assign at_end   = (cur_reg == end_reg);

    // enable edge detector
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            ten_d_reg <= 1'b0;
        end else begin
            ten_d_reg <= timer_enable_bit;
        end
    end

    // pending start load: armed by the enable rise, spent on the
    // first tick; the prescaler restarts at zero, so that tick
    // never shares a cycle with the rise
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            load_pend_reg <= 1'b0;
        end else if (!timer_enable_bit) begin
            load_pend_reg <= 1'b0;
        end else if (ten_rise) begin
            load_pend_reg <= 1'b1;
        end else if (pif.tick) begin
            load_pend_reg <= 1'b0;
        end
    end

    // current value: one step per counting tick
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            cur_reg <= aitt_pkg::CUR_RST;
        end else if (!timer_enable_bit || !pif.tick) begin
            cur_reg <= cur_reg;
        end else if (load_pend_reg) begin
            // the start load spends a tick of its own
            cur_reg <= start_reg;
        end else if (at_end) begin
            if (load_en && cont) begin
                cur_reg <= start_reg;
            end else if (!cont) begin
                cur_reg <= cur_reg;
            end else if (dir_up) begin
                cur_reg <= cur_reg + 16'h0001;
            end else begin
                cur_reg <= cur_reg - 16'h0001;
            end
        end else if (dir_up) begin
            cur_reg <= cur_reg + 16'h0001;
        end else begin
            cur_reg <= cur_reg - 16'h0001;
        end
    end

    // ---------------- trigger ----------------
    // equality counts while running and while no start load is pending; the load is
    // armed one cycle after the rise, so the reset state (both zero) fires at enable
    assign eq_q    = timer_enable_bit && !load_pend_reg && at_end;
    assign eq_rise = eq_q && !eq_d_reg;

    // delayed equality for differentiation
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            eq_d_reg <= 1'b0;
        end else begin
            eq_d_reg <= eq_q;
        end
    end

    // two-cycle pulse; a stopped count stays equal and fires once
    always_ff @(posedge CLK_SYS_I) begin
        if (!RST_N_I) begin
            trig_reg     <= 1'b0;
            trig_cnt_reg <= 2'h0;
        end else if (eq_rise) begin
            trig_reg     <= out_en;
            trig_cnt_reg <= aitt_pkg::TRIG_LAST;
        end else if (trig_cnt_reg != 2'h0) begin
            trig_reg     <= out_en;
            trig_cnt_reg <= trig_cnt_reg - 2'h1;
        end else begin
            trig_reg     <= 1'b0;
        end
    end

    assign ADC_INJECT_TRIGGER_O = trig_reg;

endmodule

// [verif/aitt_adc_model.sv]
// behavioural adc injection input that measures trigger pulses
`timescale 1ns/10ps
module aitt_adc_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       trig_i,   // trigger from the timer
    output logic            rise_o,   // first high sample of a pulse
    output logic            fall_o,   // first low sample after a pulse
    output logic [7:0]      len_o,    // high samples of the current pulse
    output logic [7:0]      cnt_o     // pulses seen since reset
);
    logic prev_reg;                   // trigger one sample ago
    // injection starts on the edge only, so a long level is one request
    assign rise_o = trig_i && !prev_reg;
    assign fall_o = !trig_i && prev_reg;
    // track level, width and number of requests
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            len_o    <= 8'h00;
            cnt_o    <= 8'h00;
        end else begin
            prev_reg <= trig_i;
            len_o    <= trig_i ? len_o + 8'h01 : 8'h00;
            if (rise_o) cnt_o <= cnt_o + 8'h01;
        end
    end
endmodule

// [verif/aitt_timer_monitor.sv]
// concurrent checks on the timer's bus and trigger ports
`timescale 1ns/10ps
module aitt_timer_monitor (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_N_I,
    input wire logic        S_AXI_AWVALID_I,
    input wire logic        S_AXI_AWREADY_O,
    input wire logic        S_AXI_WVALID_I,
    input wire logic        S_AXI_WREADY_O,
    input wire logic [1:0]  S_AXI_BRESP_O,
    input wire logic        S_AXI_BVALID_O,
    input wire logic        S_AXI_BREADY_I,
    input wire logic [31:0] S_AXI_ARADDR_I,
    input wire logic        S_AXI_ARVALID_I,
    input wire logic        S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0]  S_AXI_RRESP_O,
    input wire logic        S_AXI_RVALID_O,
    input wire logic        ADC_INJECT_TRIGGER_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    logic rd_unmapped;  // read address hits none of the four registers
    assign rd_unmapped = !(S_AXI_ARADDR_I inside {aitt_pkg::CTRL_ADDR,
        aitt_pkg::START_ADDR, aitt_pkg::END_ADDR, aitt_pkg::CUR_ADDR});
    // both write halves taken at one edge
    sequence wr_take_s;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    // read address taken
    sequence rd_take_s;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    // trigger stays high for exactly two cycles
    sequence pulse_s;
        ADC_INJECT_TRIGGER_O ##1 !ADC_INJECT_TRIGGER_O;
    endsequence
    // the held pair is committed one edge later, bvalid shows after that
    wr_answer_a: assert property (wr_take_s |=> ##1 S_AXI_BVALID_O)
        else $error("write response missing");
    rd_upper_a: assert property (rd_take_s |=> S_AXI_RVALID_O
        && S_AXI_RDATA_O[31:16] == 16'h0000) else $error("read answer bad");
    unmapped_rd_a: assert property (rd_take_s ##0 rd_unmapped |=>
        S_AXI_RRESP_O == aitt_pkg::RESP_SLVERR && S_AXI_RDATA_O == 32'h0)
        else $error("unmapped read not refused");
    mapped_rd_a: assert property (rd_take_s ##0 !rd_unmapped |=>
        S_AXI_RRESP_O == aitt_pkg::RESP_OKAY) else $error("mapped read err");
    b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=>
        S_AXI_BVALID_O && $stable(S_AXI_BRESP_O)) else $error("bresp dropped");
    w_block_a: assert property (S_AXI_BVALID_O |->
        !S_AXI_AWREADY_O && !S_AXI_WREADY_O) else $error("write not blocked");
    ar_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read not blocked");
    trig_pulse_a: assert property ($rose(ADC_INJECT_TRIGGER_O)
        |=> pulse_s) else $error("trigger pulse width wrong");
endmodule
bind aitt_timer aitt_timer_monitor u_mon (.CLK_SYS_I(CLK_SYS_I),
    .RST_N_I(RST_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
    .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARADDR_I(S_AXI_ARADDR_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
    .ADC_INJECT_TRIGGER_O(ADC_INJECT_TRIGGER_O));

// [verif/tb.sv]
// self-checking bench for the injection trigger timer
`timescale 1ns/10ps
module tb;
    logic        CLK_SYS_I, RST_N_I;              // clock, reset
    logic [31:0] S_AXI_AWADDR_I, S_AXI_WDATA_I;   // write payload
    logic [31:0] S_AXI_ARADDR_I, S_AXI_RDATA_O;   // read payload
    logic [2:0]  S_AXI_AWPROT_I, S_AXI_ARPROT_I;  // tied, ignored
    logic [3:0]  S_AXI_WSTRB_I;                   // tied, all lanes
    logic [1:0]  S_AXI_BRESP_O, S_AXI_RRESP_O;    // responses
    logic        S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I;
    logic        S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_BREADY_I;
    logic        S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic        S_AXI_RREADY_I, ADC_INJECT_TRIGGER_O;
    logic        rise, fall;                      // partner events
    logic [7:0]  len, cnt;                        // partner measures
    int          cyc, n_errors, total_checks, d;  // d: last write done
    logic [33:0] b_q[$], r_q[$], t_q[$];          // expected results
    aitt_timer dut (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I),
        .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWPROT_I(S_AXI_AWPROT_I),
        .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
        .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
        .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
        .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
        .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
        .S_AXI_ARPROT_I(S_AXI_ARPROT_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
        .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
        .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
        .S_AXI_RREADY_I(S_AXI_RREADY_I),
        .ADC_INJECT_TRIGGER_O(ADC_INJECT_TRIGGER_O));
    aitt_adc_model u_adc (.clk_i(CLK_SYS_I), .rst_n_i(RST_N_I),
        .trig_i(ADC_INJECT_TRIGGER_O), .rise_o(rise), .fall_o(fall),
        .len_o(len), .cnt_o(cnt));
    // free-running clock, 10 ns period
    initial begin
        CLK_SYS_I = 1'b0;
        forever #5 CLK_SYS_I = ~CLK_SYS_I;
    end
    // compare one result, count it, report a mismatch
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // write one word; bready sometimes late so the response must stand
    task automatic wr(input logic [31:0] a, input logic [31:0] v,
                      input logic [1:0] r);
        b_q.push_back({r, 32'h0});
        S_AXI_AWADDR_I  <= a;
        S_AXI_WDATA_I   <= v;
        S_AXI_AWVALID_I <= 1'b1;
        S_AXI_WVALID_I  <= 1'b1;
        S_AXI_BREADY_I  <= 1'($urandom);
        do begin
            @(posedge CLK_SYS_I);
            if (S_AXI_AWREADY_O) S_AXI_AWVALID_I <= 1'b0;
            if (S_AXI_WREADY_O) S_AXI_WVALID_I <= 1'b0;
            // the register lands at the last edge before bvalid shows,
            // so d does not shift with a late bready
            if (!S_AXI_BVALID_O) d = cyc + 1;
            if (S_AXI_BVALID_O && !S_AXI_BREADY_I) S_AXI_BREADY_I <= 1'b1;
        end while (!(S_AXI_BVALID_O && S_AXI_BREADY_I));
        if (S_AXI_BREADY_I) S_AXI_BREADY_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask
    // read one word and note what it must return
    task automatic rd(input logic [31:0] a, input logic [33:0] exp);
        r_q.push_back(exp);
        S_AXI_ARADDR_I  <= a;
        S_AXI_ARVALID_I <= 1'b1;
        S_AXI_RREADY_I  <= 1'b1;
        do begin
            @(posedge CLK_SYS_I);
            if (S_AXI_ARREADY_O) S_AXI_ARVALID_I <= 1'b0;
        end while (!S_AXI_RVALID_O);
        S_AXI_RREADY_I <= 1'b0;
        @(posedge CLK_SYS_I);
    endtask
    // wait to an absolute cycle count
    task automatic upto(input int c);
        while (cyc < c) @(posedge CLK_SYS_I);
    endtask
    // cycle count and hang guard; a run takes well under 1000 cycles
    always @(posedge CLK_SYS_I) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            test_done();
        end
    end
    // watcher: oldest note against each result that appears
    always @(posedge CLK_SYS_I) begin
        if (S_AXI_BVALID_O && S_AXI_BREADY_I) chk({S_AXI_BRESP_O, 32'h0},
            b_q.pop_front());
        if (S_AXI_RVALID_O && S_AXI_RREADY_I) chk({S_AXI_RRESP_O,
            S_AXI_RDATA_O}, r_q.pop_front());
        if (rise) chk(34'(cyc), t_q.pop_front());
        if (fall) chk(34'(len), 34'(aitt_pkg::TRIG_CYCLES));
    end
    initial begin
        logic [15:0] sv;  // random start value
        {RST_N_I, S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} = '0;
        {S_AXI_ARVALID_I, S_AXI_RREADY_I, S_AXI_AWPROT_I} = '0;
        {S_AXI_AWADDR_I, S_AXI_WDATA_I, S_AXI_ARADDR_I} = '0;
        S_AXI_ARPROT_I = 3'h0;
        S_AXI_WSTRB_I = 4'hf;
        {cyc, n_errors, total_checks, d} = '0;
        sv = 16'($urandom(75012));
        repeat (4) @(posedge CLK_SYS_I);
        RST_N_I <= 1'b1;
        repeat (2) @(posedge CLK_SYS_I);
        // reset values, unmapped place refused
        rd(aitt_pkg::CTRL_ADDR, 34'h0);
        rd(aitt_pkg::START_ADDR, 34'h0);
        rd(aitt_pkg::END_ADDR, 34'h0);
        rd(aitt_pkg::CUR_ADDR, 34'h0);
        rd(32'h00030020, {aitt_pkg::RESP_SLVERR, 32'h0});
        wr(32'h00030020, 32'h1234, aitt_pkg::RESP_SLVERR);
        $display("test 1 done");
        // full 16-bit start/end, read-only current, masked control
        sv = 16'($urandom);
        wr(aitt_pkg::START_ADDR, {16'hffff, sv}, 2'h0);
        rd(aitt_pkg::START_ADDR, {18'h0, sv});
        wr(aitt_pkg::END_ADDR, 32'habcd5a5a, 2'h0);
        rd(aitt_pkg::END_ADDR, 34'h5a5a);
        wr(aitt_pkg::CUR_ADDR, 32'h7777, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'hfc1e, 2'h0);
        rd(aitt_pkg::CTRL_ADDR, 34'h001e);
        rd(aitt_pkg::CUR_ADDR, 34'h0);
        $display("test 2 done");
        // up 0..9, stop at end, one pulse
        wr(aitt_pkg::CTRL_ADDR, 32'h12, 2'h0);
        wr(aitt_pkg::START_ADDR, 32'h0, 2'h0);
        wr(aitt_pkg::END_ADDR, 32'h9, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'h13, 2'h0);
        t_q.push_back(34'(d + 4 * 10 + 1));
        upto(d + 60);
        rd(aitt_pkg::CUR_ADDR, 34'h9);
        $display("test 3 done");
        // down 5..3 with reload, divide by 8, disable holds count
        wr(aitt_pkg::CTRL_ADDR, 32'h12, 2'h0);
        wr(aitt_pkg::START_ADDR, 32'h5, 2'h0);
        wr(aitt_pkg::END_ADDR, 32'h3, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'h5c, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'h5d, 2'h0);
        t_q.push_back(34'(d + 8 * 3 + 1));
        t_q.push_back(34'(d + 8 * 6 + 1));
        upto(d + 58);
        wr(aitt_pkg::CTRL_ADDR, 32'h5c, 2'h0);
        upto(d + 30);
        rd(aitt_pkg::CUR_ADDR, 34'h5);
        $display("test 4 done");
        // up, continue past end with output disabled
        wr(aitt_pkg::START_ADDR, 32'hfffe, 2'h0);
        wr(aitt_pkg::END_ADDR, 32'hffff, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'h0a, 2'h0);
        wr(aitt_pkg::CTRL_ADDR, 32'h0b, 2'h0);
        upto(d + 12);
        wr(aitt_pkg::CTRL_ADDR, 32'h0a, 2'h0);
        rd(aitt_pkg::CUR_ADDR, 34'h0);
        chk(34'(cnt), 34'h3);
        chk(34'(t_q.size()), 34'h0);
        $display("test 5 done");
        test_done();
    end
endmodule
